//--- logic/wdog_supervisor.sv
// Software watchdog and oscillator supervisor with AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module wdog_supervisor
    import wdog_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_reset_b,
    input wire logic xtal_osc,
    input wire logic rc_osc,
    input wire logic ext_interrupt_pin_zero,
    input wire logic receive_pin_alt,
    input wire logic idle_mode,
    input wire logic power_down_mode,
    output logic sys_reset_out,
    output logic clk_sel_rc,
    output logic osc_enable,
    output logic wakeup_irq
);
    wdog_state_t st;
    wdog_state_t nx;
    logic [4:0] rise;
    logic ext_req;
    logic mc_tick;
    logic wd_tick;
    logic halt;
    logic timeout_hit;
    logic win_done;
    logic win_fail;
    logic wr_start;
    logic wake_pin_low;
    logic [7:0] wd;
    logic [7:0] rd_idx;

    // Word index of a byte address, or none when outside the map
    function automatic logic [7:0] idx_of(input logic [31:0] a);
        logic [7:0] i;
        i = a[9:2];
        if (a[31:10] != 22'h0 || a[1:0] != 2'h0) begin
            return IDX_NONE;
        end
        if (i == IDX_RELOAD || i == IDX_POWER_CONTROL_REG1 || i == IDX_INTERRUPT_ENABLE_REG0 || i == IDX_IP0
            || i == IDX_INTERRUPT_ENABLE_REG1 || i == IDX_COUNT) begin
            return i;
        end
        return IDX_NONE;
    endfunction

    function automatic logic [31:0] rd_mux(input wdog_state_t s, input logic [7:0] i);
        logic [31:0] r;
        r = 32'h0;
        unique case (i)
            IDX_RELOAD: r = {24'h0, s.reload};
            IDX_POWER_CONTROL_REG1: r = {24'h0, s.power_control_reg1};
            IDX_INTERRUPT_ENABLE_REG0: r = {24'h0, s.interrupt_enable_reg0};
            IDX_IP0: r = {24'h0, s.ip0};
            IDX_INTERRUPT_ENABLE_REG1: r = {24'h0, s.interrupt_enable_reg1};
            IDX_COUNT: r = {17'h0, s.cnt};
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    always_comb begin
        nx = st;
        // Pin synchronisers; a change counts once stages two and three agree
        nx.sync1 = {receive_pin_alt, ext_interrupt_pin_zero, rc_osc, xtal_osc, ext_reset_b};
        nx.sync2 = st.sync1;
        nx.sync3 = st.sync2;
        nx.level = (st.sync2 & st.sync3) | (st.level & (st.sync2 | st.sync3));
        nx.level_prev = st.level;
        rise = st.level & ~st.level_prev;
        ext_req = !st.level[PIN_EXT_RST];
        nx.pd_prev = power_down_mode;
        nx.wake_irq = 1'b0;

        // Machine cycle and optional extra prescaler
        mc_tick = (st.mc_cnt == 4'(MC_CLKS - 1)); // see [R24]
        nx.mc_cnt = mc_tick ? 4'h0 : st.mc_cnt + 4'h1;
        if (mc_tick) begin
            nx.xpre_cnt = st.xpre_cnt + 4'h1;
        end
        wd_tick = mc_tick && (!st.reload[BIT_PSEL]
            || st.xpre_cnt == 4'(XPRE_DIV - 1)); // see [R1] [R23]

        // Counter runs only while started and the CPU is active
        halt = idle_mode || power_down_mode || st.wdt_pulse; // see [R9]
        if (st.interrupt_enable_reg1[BIT_START] && !halt && wd_tick) begin
            nx.cnt = st.cnt + 15'h1;
        end
        timeout_hit = st.interrupt_enable_reg1[BIT_START] && !halt
            && st.cnt == TIMEOUT_STATE; // see [R12]

        // Refresh request ages out at the second machine-cycle boundary
        if (st.interrupt_enable_reg0[BIT_REFRESH] && mc_tick) begin
            nx.rf_age = 1'b1;
            if (st.rf_age) begin
                nx.interrupt_enable_reg0[BIT_REFRESH] = 1'b0; // see [R10]
                nx.rf_age = 1'b0;
            end
        end

        // Bus data phase write
        wd = hwdata[7:0];
        wr_start = 1'b0;
        if (st.wr_pend) begin
            unique case (st.wr_idx)
                IDX_RELOAD: nx.reload = wd; // see [R7]
                IDX_POWER_CONTROL_REG1: nx.power_control_reg1 = wd;
                IDX_INTERRUPT_ENABLE_REG0: begin
                    nx.interrupt_enable_reg0 = wd;
                    if (wd[BIT_REFRESH]) begin
                        nx.rf_age = 1'b0;
                    end
                end
                IDX_IP0: nx.ip0 = wd; // see [R4] [R20]
                IDX_INTERRUPT_ENABLE_REG1: begin
                    // Start bit cannot be cleared once set
                    nx.interrupt_enable_reg1 = wd | (st.interrupt_enable_reg1 & (8'h01 << BIT_START)); // see [R8]
                    if (wd[BIT_START]) begin
                        // Start a stopped dog, or refresh when the request stands
                        if (!st.interrupt_enable_reg1[BIT_START] || st.interrupt_enable_reg0[BIT_REFRESH]) begin // see [R2] [R3]
                            wr_start = 1'b1;
                            nx.cnt = {st.reload[6:0], 8'h00}; // see [R5] [R25]
                        end
                    end
                end
                default: ;
            endcase
        end

        // Timeout reset pulse, length latched from prescale select
        if (timeout_hit) begin
            nx.wdt_pulse = 1'b1;
            nx.pulse_cnt = 8'h00;
            nx.pulse_len = st.reload[BIT_PSEL] ? 8'(PULSE_LONG - 1)
                : 8'(PULSE_SHORT - 1); // see [R13]
        end else if (st.wdt_pulse) begin
            nx.pulse_cnt = st.pulse_cnt + 8'h01;
            if (st.pulse_cnt == st.pulse_len) begin
                nx.wdt_pulse = 1'b0;
                nx.cnt = {st.reload[6:0], 8'h00};
            end
        end
        if (nx.wdt_pulse) begin
            // Acts as a system reset but the dog keeps running
            nx.interrupt_enable_reg0 = REG_RESET;
            nx.power_control_reg1 = REG_RESET;
            nx.reload = REG_RESET; // see [R6]
            nx.interrupt_enable_reg1 = REG_RESET;
            nx.interrupt_enable_reg1[BIT_START] = 1'b1; // see [R14]
            nx.ip0 = REG_RESET;
            nx.ip0[BIT_WD_STAT] = 1'b1; // see [R4] [R14]
            nx.rf_age = 1'b0;
        end

        // Oscillator comparison window of RC_DIV reference edges
        win_done = 1'b0;
        win_fail = 1'b0;
        if (rise[PIN_RC]) begin
            if (st.rc_cnt == 4'(RC_DIV - 1)) begin
                win_done = 1'b1;
                win_fail = !(st.xtal_seen || rise[PIN_XTAL]); // see [R15]
                nx.rc_cnt = 4'h0;
                nx.xtal_seen = 1'b0;
            end else begin
                nx.rc_cnt = st.rc_cnt + 4'h1;
                nx.xtal_seen = st.xtal_seen || rise[PIN_XTAL];
            end
        end else if (rise[PIN_XTAL]) begin
            nx.xtal_seen = 1'b1;
        end

        wake_pin_low = st.power_control_reg1[BIT_WAKE_SRC] ? !st.level[PIN_RXD] : !st.level[PIN_EXT_INTERRUPT_PIN_ZERO];
        unique case (st.osc)
            OSC_RUN: begin
                if (win_done && win_fail) begin
                    nx.osc = OSC_FAIL;
                    nx.osc_rst = 1'b1; // see [R16]
                    nx.clk_sel_rc = 1'b1;
                end else if (power_down_mode && !st.pd_prev) begin
                    nx.osc = OSC_SLEEP;
                    nx.osc_run = 1'b0; // see [R21]
                end
            end
            OSC_FAIL: begin
                if (win_done && !win_fail) begin
                    nx.osc = OSC_SETTLE;
                    nx.settle_cnt = 24'h0;
                end
            end
            OSC_SETTLE: begin
                if (win_done && win_fail) begin
                    nx.osc = OSC_FAIL;
                end else if (st.settle_cnt == 24'(SETTLE_CYCLES - 1)) begin
                    nx.osc = OSC_RUN;
                    nx.osc_rst = 1'b0; // see [R18]
                    nx.clk_sel_rc = 1'b0;
                end else begin
                    nx.settle_cnt = st.settle_cnt + 24'h1;
                end
            end
            OSC_SLEEP: begin
                if (st.power_control_reg1[BIT_WAKE_EN] && wake_pin_low) begin // see [R21]
                    nx.osc = OSC_WAKE;
                    nx.osc_run = 1'b1;
                    nx.clk_sel_rc = 1'b1;
                end
            end
            OSC_WAKE: begin
                if (win_done && !win_fail) begin
                    nx.osc = OSC_WSETTLE;
                    nx.settle_cnt = 24'h0;
                end
            end
            OSC_WSETTLE: begin
                if (st.settle_cnt == 24'(SETTLE_CYCLES - 1)) begin
                    nx.osc = OSC_RUN;
                    nx.clk_sel_rc = 1'b0;
                    nx.wake_irq = 1'b1; // see [R22]
                end else begin
                    nx.settle_cnt = st.settle_cnt + 24'h1;
                end
            end
            default: nx.osc = OSC_FAIL;
        endcase

        // Supervisor reset: clears all but the timeout flag, sets the failure flag, stops the dog
        if (nx.osc_rst) begin
            nx.interrupt_enable_reg0 = REG_RESET;
            nx.interrupt_enable_reg1 = REG_RESET; // see [R17]
            nx.power_control_reg1 = REG_RESET;
            nx.reload = REG_RESET; // see [R6]
            nx.ip0 = st.ip0 & (8'h01 << BIT_WD_STAT);
            nx.ip0[BIT_OSC_STAT] = 1'b1; // see [R17]
            nx.cnt = 15'h0;
            nx.rf_age = 1'b0;
        end
        if (ext_req) begin
            nx.interrupt_enable_reg0 = REG_RESET;
            nx.interrupt_enable_reg1 = REG_RESET;
            nx.power_control_reg1 = REG_RESET;
            nx.reload = REG_RESET; // see [R6]
            nx.ip0 = REG_RESET; // see [R20]
            nx.cnt = 15'h0;
            nx.rf_age = 1'b0;
            if (nx.osc_rst) begin
                nx.ip0[BIT_OSC_STAT] = 1'b1;
            end
        end
        nx.sys_rst = nx.osc_rst || nx.wdt_pulse || ext_req; // see [R19]

        // Bus address phase; read data reflects any write landing now
        rd_idx = idx_of(haddr);
        nx.wr_pend = 1'b0;
        nx.hready = 1'b1;
        nx.hresp = 1'b0;
        if (hsel && hready && htrans[1]) begin
            nx.wr_pend = hwrite;
            nx.wr_idx = rd_idx;
            nx.hrdata = hwrite ? 32'h0 : rd_mux(nx, rd_idx);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{sync1: PIN_IDLE, sync2: PIN_IDLE, sync3: PIN_IDLE, level: PIN_IDLE,
                level_prev: PIN_IDLE, wr_idx: IDX_NONE, hready: 1'b1, osc: OSC_FAIL,
                osc_rst: 1'b1, clk_sel_rc: 1'b1, osc_run: 1'b1, sys_rst: 1'b1,
                default: '0};
        end else begin
            st <= nx;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = st.hready;
    assign hresp = st.hresp;
    assign sys_reset_out = st.sys_rst;
    assign clk_sel_rc = st.clk_sel_rc;
    assign osc_enable = st.osc_run;
    assign wakeup_irq = st.wake_irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    property p_start_load;
        wr_start && !ext_req && !st.osc_rst && !timeout_hit && !st.wdt_pulse
        |=> st.interrupt_enable_reg1[BIT_START] && st.cnt[14:8] == $past(st.reload[6:0]);
    endproperty
    a_start_load: assert property (p_start_load) // see [R3] [R5] [R25]
        else $error("start or refresh did not load the reload value");

    property p_refresh_ages;
        $rose(st.interrupt_enable_reg0[BIT_REFRESH]) |-> ##[1:24] !st.interrupt_enable_reg0[BIT_REFRESH];
    endproperty
    a_refresh_ages: assert property (p_refresh_ages) // see [R10]
        else $error("refresh request did not clear itself");

    property p_no_stop;
        st.interrupt_enable_reg1[BIT_START] && !ext_req && !nx.osc_rst |=> st.interrupt_enable_reg1[BIT_START];
    endproperty
    a_no_stop: assert property (p_no_stop) // see [R8]
        else $error("running watchdog stopped without a reset");

    property p_halt;
        (idle_mode || power_down_mode) && !st.wr_pend && !st.wdt_pulse
            && !ext_req && !nx.osc_rst |=> $stable(st.cnt);
    endproperty
    a_halt: assert property (p_halt) // see [R9]
        else $error("counter moved in idle or power-down");

    property p_pulse_len;
        $rose(st.wdt_pulse) |-> st.wdt_pulse[*8] ##1
            (!st.wdt_pulse || st.pulse_len == 8'(PULSE_LONG - 1));
    endproperty
    a_pulse_len: assert property (p_pulse_len) // see [R13]
        else $error("timeout reset pulse has wrong length");

    property p_timeout_flag;
        timeout_hit && !ext_req && !st.osc_rst |=> st.wdt_pulse ##1
            (st.sys_rst && st.ip0[BIT_WD_STAT] && st.interrupt_enable_reg1[BIT_START]);
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) // see [R4] [R12] [R14]
        else $error("timeout did not reset and set the status flag");

    property p_fail_switch;
        st.osc == OSC_RUN && win_done && win_fail
        |=> st.clk_sel_rc && st.osc_rst ##1 st.sys_rst && st.ip0[BIT_OSC_STAT];
    endproperty
    a_fail_switch: assert property (p_fail_switch) // see [R16] [R17]
        else $error("failure did not select RC clock with reset");

    property p_ext_clear;
        ext_req |=> st.ip0[BIT_WD_STAT] == 1'b0 && st.reload == REG_RESET && st.sys_rst;
    endproperty
    a_ext_clear: assert property (p_ext_clear) // see [R6] [R20]
        else $error("external reset left flags or reload set");

    property p_wake_no_reset;
        st.osc == OSC_SLEEP |=> !st.osc_rst [*2];
    endproperty
    a_wake_no_reset: assert property (p_wake_no_reset) // see [R22]
        else $error("supervisor reset during power-down wake-up");

    property p_hold_reset;
        !st.osc_rst && $past(st.osc_rst) && $past(ext_req) && ext_req |-> st.sys_rst;
    endproperty
    a_hold_reset: assert property (p_hold_reset) // see [R19]
        else $error("reset released while external request still active");
endmodule

//--- include/wdog_pkg.sv
// Constants and state types of the software watchdog and oscillator supervisor
// Notes on behaviour
// [R1] Timeouts 32.768 ms, 524.2 ms, 256 us at 12 MHz
// [R2] Refresh request must directly precede start flag
// [R3] Start flag activates counter, or refreshes after request
// [R4] Timeout sets status flag; software sets and clears
// [R5] Start loads upper seven bits from reload
// [R6] Reload clears on external, supervisor, timeout reset
// [R7] Reload low seven bits writable at any time
// [R8] Started watchdog cannot be stopped by software
// [R9] Counter halts in idle and power-down
// [R10] Refresh request self-clears in second machine cycle
// [R11] Software issues start right after refresh request
// [R12] Timeout reset entered at counter state 7FFC
// [R13] Timeout reset lasts 8 or 128 cycles
// [R14] Timeout reset keeps watchdog running, sets status bit 6
// [R15] Supervisor always on, compares against RC divided by 10
// [R16] Failure selects RC clock and asserts reset together
// [R17] Supervisor reset keeps timeout flag, stops counter
// [R18] Recovery holds reset 1 ms, then releases
// [R19] Reset held while external or timeout reset remains
// [R20] Failure flag writable; external reset clears both flags; code keeps failure flag set while supervisor reset is active
// [R21] Power-down stops oscillators until enabled pin wakes
// [R22] Wake-up gives interrupt, no supervisor reset
// [R23] Prescale select adds divide-by-16 stage
// [R24] Counter ticks at oscillator divided by 12
// [R25] Refresh copies reload into upper seven bits
package wdog_pkg;
    localparam int CLK_NS = 40;
    localparam int MC_CLKS = 12;
    localparam int XPRE_DIV = 16;
    localparam int RC_DIV = 10;
    localparam int PULSE_SHORT = 8;
    localparam int PULSE_LONG = 128;
    localparam int SETTLE_NS = 1000000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [14:0] TIMEOUT_STATE = 15'h7FFC;
    localparam logic [7:0] IDX_RELOAD = 8'h86;
    localparam logic [7:0] IDX_POWER_CONTROL_REG1 = 8'h88;
    localparam logic [7:0] IDX_INTERRUPT_ENABLE_REG0 = 8'hA8;
    localparam logic [7:0] IDX_IP0 = 8'hA9;
    localparam logic [7:0] IDX_INTERRUPT_ENABLE_REG1 = 8'hB8;
    localparam logic [7:0] IDX_COUNT = 8'hC0;
    localparam logic [7:0] IDX_NONE = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int BIT_REFRESH = 6;
    localparam int BIT_START = 6;
    localparam int BIT_WD_STAT = 6;
    localparam int BIT_OSC_STAT = 5;
    localparam int BIT_PSEL = 7;
    localparam int BIT_WAKE_EN = 7;
    localparam int BIT_WAKE_SRC = 4;
    localparam int PIN_EXT_RST = 0;
    localparam int PIN_XTAL = 1;
    localparam int PIN_RC = 2;
    localparam int PIN_EXT_INTERRUPT_PIN_ZERO = 3;
    localparam int PIN_RXD = 4;
    localparam logic [4:0] PIN_IDLE = 5'h19;

    typedef enum logic [2:0] {
        OSC_RUN, OSC_FAIL, OSC_SETTLE, OSC_SLEEP, OSC_WAKE, OSC_WSETTLE
    } osc_state_t;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] level;
        logic [4:0] level_prev;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        logic [7:0] interrupt_enable_reg0;
        logic [7:0] ip0;
        logic [7:0] interrupt_enable_reg1;
        logic [7:0] reload;
        logic [7:0] power_control_reg1;
        logic [14:0] cnt;
        logic [3:0] mc_cnt;
        logic [3:0] xpre_cnt;
        logic rf_age;
        logic wdt_pulse;
        logic [7:0] pulse_cnt;
        logic [7:0] pulse_len;
        osc_state_t osc;
        logic [3:0] rc_cnt;
        logic xtal_seen;
        logic [23:0] settle_cnt;
        logic osc_rst;
        logic clk_sel_rc;
        logic osc_run;
        logic wake_irq;
        logic sys_rst;
        logic pd_prev;
    } wdog_state_t;
endpackage

//--- tb/watchdog_and_osc_supervisor_bench.sv
// Self-checking bench for the watchdog and oscillator supervisor
`timescale 1ns/100ps
module watchdog_and_osc_supervisor_bench import wdog_pkg::*;;
    `define CHECK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [31:0] exp;
    } row_t;

    logic clock, rst_b, hsel, hwrite, ext_reset_b, xtal_osc, rc_osc, xtal_on;
    logic ext_interrupt_pin_zero, receive_pin_alt, idle_mode, power_down_mode;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, x, y;
    logic hreadyout, hresp, sys_reset_out, clk_sel_rc, osc_enable, wakeup_irq, rst_seen;
    logic [2:0] ph = 3'h0;
    int fail_count, checked, n;
    row_t rows [10] = '{
        '{1'b0, IDX_RELOAD, 8'h00, 32'h0}, '{1'b0, IDX_INTERRUPT_ENABLE_REG0, 8'h00, 32'h0},
        '{1'b0, IDX_IP0, 8'h00, 32'h20}, '{1'b0, IDX_INTERRUPT_ENABLE_REG1, 8'h00, 32'h0},
        '{1'b1, IDX_RELOAD, 8'h85, 32'h85}, '{1'b1, IDX_INTERRUPT_ENABLE_REG0, 8'h0F, 32'h0F},
        '{1'b1, IDX_IP0, 8'h60, 32'h60}, '{1'b1, IDX_IP0, 8'h00, 32'h0},
        '{1'b1, 8'h90, 8'hAA, 32'h0}, '{1'b1, IDX_RELOAD, 8'h00, 32'h0}};

    wdog_supervisor #(.SETTLE_CYCLES(20)) u_dut (
        .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_reset_b(ext_reset_b),
        .xtal_osc(xtal_osc), .rc_osc(rc_osc), .ext_interrupt_pin_zero(ext_interrupt_pin_zero),
        .receive_pin_alt(receive_pin_alt), .idle_mode(idle_mode),
        .power_down_mode(power_down_mode), .sys_reset_out(sys_reset_out),
        .clk_sel_rc(clk_sel_rc), .osc_enable(osc_enable), .wakeup_irq(wakeup_irq));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Oscillators stop while the block has them disabled
    always @(posedge clock) begin
        ph <= ph + 3'h1;
        xtal_osc <= osc_enable & xtal_on & ph[1];
        rc_osc <= osc_enable & ph[2];
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        hsize <= 3'b010;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        ahb(1'b1, idx, wd, d);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        ahb(1'b0, idx, 8'h00, d);
    endtask

    // Cycles until the internal reset reaches the given level
    task automatic wait_rst(input logic v, output int c);
        c = 0;
        while (sys_reset_out !== v && c < 5000) begin
            @(posedge clock);
            #1;
            c++;
        end
    endtask

    // Stop the crystal, then let it recover, optionally under external reset
    task automatic osc_fail(input logic hold_ext, input logic [31:0] ip0_exp);
        @(posedge clock);
        xtal_on <= 1'b0;
        wait_rst(1'b1, n);
        `CHECK("fail detect", 1'b1, n < 300)
        `CHECK("rc select", 1'b1, clk_sel_rc)
        @(posedge clock);
        xtal_on <= 1'b1;
        ext_reset_b <= ~hold_ext;
        if (hold_ext) begin
            repeat (300) @(posedge clock);
            #1;
            `CHECK("held by ext", 1'b1, sys_reset_out)
            @(posedge clock);
            ext_reset_b <= 1'b1;
        end
        wait_rst(1'b0, n);
        `CHECK("settle", 1'b1, hold_ext ? n < 20 : n >= 20 && n < 300)
        `CHECK("xtal select", 1'b0, clk_sel_rc)
        rd(IDX_IP0, x);
        `CHECK("flags", ip0_exp, x)
        rd(IDX_INTERRUPT_ENABLE_REG1, x);
        `CHECK("dog stopped", 32'h0, x)
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        fail_count++;
        $display("[FAIL] watchdog expected done seen hang");
        end_of_test();
    end

    initial begin
        rst_b = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; ext_reset_b = 1'b1;
        xtal_osc = 1'b0; rc_osc = 1'b0; xtal_on = 1'b1; ext_interrupt_pin_zero = 1'b1;
        receive_pin_alt = 1'b1; idle_mode = 1'b0; power_down_mode = 1'b0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        wait_rst(1'b0, n);
        `CHECK("power-on release", 1'b1, n < 1000)
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
            rd(rows[i].idx, x);
            `CHECK("register", rows[i].exp, x)
            `CHECK("okay", 1'b0, hresp)
            `CHECK("ready", 1'b1, hreadyout)
        end
        $display("test registers done");

        wr(IDX_RELOAD, 8'h7F);
        wr(IDX_INTERRUPT_ENABLE_REG1, 8'h40);
        rd(IDX_COUNT, x);
        `CHECK("start load", 7'h7F, x[14:8])
        wait_rst(1'b1, n);
        `CHECK("timeout", 1'b1, n > 2980 && n < 3040)
        wait_rst(1'b0, n);
        `CHECK("pulse", 8, n)
        rd(IDX_RELOAD, x);
        `CHECK("reload cleared", 32'h0, x)
        rd(IDX_IP0, x);
        `CHECK("timeout flag", 32'h40, x)
        rd(IDX_INTERRUPT_ENABLE_REG1, x);
        `CHECK("still running", 1'b1, x[6])
        $display("test timeout done");

        wr(IDX_RELOAD, 8'h7F);
        wr(IDX_INTERRUPT_ENABLE_REG0, 8'h40);
        wr(IDX_INTERRUPT_ENABLE_REG1, 8'h40);
        rd(IDX_COUNT, x);
        `CHECK("refresh", 7'h7F, x[14:8])
        @(posedge clock);
        idle_mode <= 1'b1;
        rd(IDX_COUNT, x);
        repeat (60) @(posedge clock);
        rd(IDX_COUNT, y);
        `CHECK("idle halt", x, y)
        @(posedge clock);
        idle_mode <= 1'b0;
        repeat (600) @(posedge clock);
        wr(IDX_INTERRUPT_ENABLE_REG0, 8'h40);
        repeat (30) @(posedge clock);
        rd(IDX_INTERRUPT_ENABLE_REG0, x);
        `CHECK("request cleared", 1'b0, x[6])
        wr(IDX_INTERRUPT_ENABLE_REG1, 8'h40);
        wr(IDX_INTERRUPT_ENABLE_REG1, 8'h00);
        rd(IDX_COUNT, x);
        `CHECK("late start", 1'b1, x[14:0] >= 15'h7F30)
        rd(IDX_INTERRUPT_ENABLE_REG1, x);
        `CHECK("no stop", 1'b1, x[6])
        wait_rst(1'b1, n);
        wait_rst(1'b0, n);
        $display("test refresh done");

        wr(IDX_POWER_CONTROL_REG1, 8'h80);
        @(posedge clock);
        power_down_mode <= 1'b1;
        receive_pin_alt <= 1'b0;
        repeat (100) @(posedge clock);
        #1;
        `CHECK("osc stopped", 1'b0, osc_enable)
        @(posedge clock);
        ext_interrupt_pin_zero <= 1'b0;
        rst_seen = 1'b0;
        n = 0;
        while (wakeup_irq !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            rst_seen = rst_seen | sys_reset_out;
            n++;
        end
        `CHECK("wake irq", 1'b1, wakeup_irq)
        `CHECK("osc running", 1'b1, osc_enable)
        `CHECK("no reset", 1'b0, rst_seen)
        @(posedge clock);
        power_down_mode <= 1'b0;
        ext_interrupt_pin_zero <= 1'b1;
        receive_pin_alt <= 1'b1;
        $display("test wakeup done");

        // Extra prescaler: two or three ticks in about 400 clocks
        wr(IDX_RELOAD, 8'hFF);
        wr(IDX_INTERRUPT_ENABLE_REG0, 8'h40);
        wr(IDX_INTERRUPT_ENABLE_REG1, 8'h40);
        repeat (400) @(posedge clock);
        rd(IDX_COUNT, x);
        `CHECK("prescale", 1'b1, x[14:0] >= 15'h7F01 && x[14:0] <= 15'h7F03)
        $display("test prescaler done");

        osc_fail(1'b0, 32'h60);
        osc_fail(1'b1, 32'h0);
        $display("test oscillator done");
        end_of_test();
    end
endmodule
